// >>> src/data_move_instruction_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmx_params.svh"

module data_move_instruction_exec
  import dmx_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ---------------------------------------------------------------------------
  // state, decoder and data memory
  // ---------------------------------------------------------------------------
  core_state_t s_r;
  core_state_t s_nxt;
  logic [7:0] mem [0:4095];
  logic mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;
  logic [11:0] faddr;
  logic [11:0] rd_addr;
  logic [7:0] rd_byte;
  logic [11:0] daddr_eff;
  logic [31:0] rd_val;
  logic [7:0] ra;
  logic [1:0] ptr_idx;
  logic addr_phase;
  logic insn_wr;
  logic insn_ok;
  logic exec_q3;
  kind_t wkind;

  decode_if dif ();

  insn_decode u_decode (
    .dif(dif)
  );

  assign dif.word = s_r.insn;

  // bus sampling and handy terms
  assign addr_phase = hsel && htrans[1] && hready;
  assign insn_wr = s_r.wr_pend && (s_r.wr_addr == `REG_INSN);
  assign insn_ok = insn_wr && (s_r.st != ST_EXEC);
  assign exec_q3 = (s_r.st == ST_EXEC) && (s_r.q == `Q_WRITE) && !s_r.nop;
  assign wkind = s_r.word2 ? s_r.kind : dif.kind;

  // ---------------------------------------------------------------------------
  // file address resolution
  // ---------------------------------------------------------------------------
  // indexed form wins over the plain access bank only with the extended set on
  always_comb begin
    if (!dif.access_bit && s_r.ext_en && (dif.f8 <= `INDEXED_LIMIT)) begin
      faddr = s_r.ptr[`INDEX_PTR] + {4'h0, dif.f8};
    end else if (!dif.access_bit) begin
      faddr = (dif.f8 >= `ACCESS_SPLIT) ? {`ACCESS_HI_PAGE, dif.f8} : {4'h0, dif.f8};
    end else begin
      faddr = {s_r.bank_select_register, dif.f8};
    end
  end

  // operand read; the accumulator sits in the data space at one address
  assign rd_addr = (wkind == K_FULL) ? s_r.insn[11:0] : faddr;
  assign rd_byte = (rd_addr == `ACC_ADDR) ? s_r.acc : mem[rd_addr];

  // ---------------------------------------------------------------------------
  // read mux, looked up in the address phase
  // ---------------------------------------------------------------------------
  // forward a pending address write so a back-to-back data read is not stale
  assign daddr_eff = (s_r.wr_pend && s_r.wr_addr == `REG_DADDR) ? hwdata[11:0] : s_r.daddr;
  assign ra = haddr[7:0];
  assign ptr_idx = 2'(ra[4:2] - `PTR0_INDEX);

  always_comb begin
    if (ra == `REG_INSN) begin
      rd_val = {16'h0000, s_r.insn};
    end else if (ra == `REG_CTRL) begin
      rd_val = {30'h0000_0000, s_r.skip_next, s_r.ext_en};
    end else if (ra == `REG_STATUS) begin
      rd_val = {26'h000_0000, s_r.zero, s_r.neg, s_r.seq_err, s_r.overrun,
                (s_r.st == ST_WAIT), (s_r.st == ST_EXEC) || insn_ok};
    end else if (ra == `REG_ACC) begin
      rd_val = {24'h00_0000, s_r.acc};
    end else if (ra == `REG_BANK) begin
      rd_val = {28'h000_0000, s_r.bank_select_register};
    end else if (ra >= `REG_PTR0 && ra <= `REG_PTR2 && ra[1:0] == 2'h0) begin
      rd_val = {20'h0_0000, s_r.ptr[ptr_idx]};
    end else if (ra == `REG_DADDR) begin
      rd_val = {20'h0_0000, s_r.daddr};
    end else if (ra == `REG_DDATA) begin
      rd_val = {24'h00_0000, mem[daddr_eff]};
    end else begin
      rd_val = 32'h0000_0000; // unmapped reads zero, still OKAY
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_wa = 12'h000;
    mem_wd = 8'h00;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;

    // address phase: capture reads now, writes go to the data phase
    if (addr_phase && !hwrite) begin
      s_nxt.hrdata = rd_val;
    end
    s_nxt.wr_pend = addr_phase && hwrite && (hsize == `HSIZE_WORD);
    s_nxt.wr_addr = ra;

    // data phase register writes; clears come first so a set below wins
    if (s_r.wr_pend) begin
      if (s_r.wr_addr == `REG_CTRL) begin
        s_nxt.ext_en = hwdata[`CTRL_EXT_BIT];
        s_nxt.skip_next = hwdata[`CTRL_SKIP_BIT];
      end else if (s_r.wr_addr == `REG_STATUS) begin
        if (hwdata[`STAT_OVR_BIT]) begin
          s_nxt.overrun = 1'b0;
        end
        if (hwdata[`STAT_SEQ_BIT]) begin
          s_nxt.seq_err = 1'b0;
        end
      end else if (s_r.wr_addr == `REG_DADDR) begin
        s_nxt.daddr = hwdata[11:0];
      end else if (s_r.wr_addr == `REG_DDATA) begin
        // one memory write port: software loses to a running instruction
        if (s_r.st == ST_EXEC) begin
          s_nxt.overrun = 1'b1;
        end else begin
          mem_we = 1'b1;
          mem_wa = s_r.daddr;
          mem_wd = hwdata[7:0];
        end
      end
    end

    // instruction sequencer, four quarters per instruction cycle
    case (s_r.st)
      ST_IDLE: begin
        if (insn_ok) begin
          s_nxt.st = ST_EXEC;
          s_nxt.q = `Q_DECODE;
          s_nxt.insn = hwdata[15:0];
          s_nxt.word2 = 1'b0;
          s_nxt.nop = s_r.skip_next;
          s_nxt.skip_next = 1'b0;
        end
      end
      ST_WAIT: begin
        if (insn_ok) begin
          s_nxt.st = ST_EXEC;
          s_nxt.q = `Q_DECODE;
          s_nxt.insn = hwdata[15:0];
          s_nxt.word2 = 1'b1;
        end
      end
      ST_EXEC: begin
        s_nxt.q = s_r.q + 2'h1;
        if (insn_wr) begin
          s_nxt.overrun = 1'b1;
        end
        if (s_r.q == `Q_DECODE) begin
          if (!s_r.word2) begin
            s_nxt.kind = dif.kind;
            s_nxt.first = s_r.insn;
            if (dif.kind == K_PTR && dif.sel == `PTR_COUNT) begin
              s_nxt.nop = 1'b1; // no fourth pointer
            end
          end else if (dif.kind != K_SECOND) begin
            s_nxt.seq_err = 1'b1;
            s_nxt.nop = 1'b1;
          end
        end
        // source read in quarter two; a second word never reads
        if (s_r.q == `Q_READ && !s_r.nop && !s_r.word2) begin
          if (dif.kind == K_FMOVE || dif.kind == K_FULL) begin
            s_nxt.tmp = rd_byte;
          end
        end
        if (exec_q3 && !s_r.word2) begin
          case (dif.kind)
            K_PTR: begin
              s_nxt.ptr[dif.sel][11:8] = dif.k_hi;
            end
            K_FMOVE: begin
              s_nxt.neg = s_r.tmp[7];
              s_nxt.zero = (s_r.tmp == 8'h00);
              if (!dif.dest_bit || faddr == `ACC_ADDR) begin
                s_nxt.acc = s_r.tmp;
              end else begin
                mem_we = 1'b1;
                mem_wa = faddr;
                mem_wd = s_r.tmp;
              end
            end
            K_BANK: begin
              s_nxt.bank_select_register = s_r.insn[3:0];
            end
            default: begin
            end
          endcase
        end
        // destination write in quarter four of the second cycle; flags untouched
        if (exec_q3 && s_r.word2) begin
          if (s_r.kind == K_PTR) begin
            s_nxt.ptr[s_r.first[5:4]][7:0] = s_r.insn[7:0];
          end else if (s_r.kind == K_FULL) begin
            // program counter and stack bytes are not modelled here
            if (s_r.insn[11:0] == `ACC_ADDR) begin
              s_nxt.acc = s_r.tmp;
            end else begin
              mem_we = 1'b1;
              mem_wa = s_r.insn[11:0];
              mem_wd = s_r.tmp;
            end
          end
        end
        // a skipped two-word move stays squashed through word two: 2 cycles
        if (s_r.q == `Q_WRITE) begin
          if (!s_r.word2 && (dif.kind == K_PTR || dif.kind == K_FULL)) begin
            s_nxt.st = ST_WAIT;
          end else begin
            s_nxt.st = ST_IDLE;
            s_nxt.nop = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.acc <= `ACC_RESET;
      s_r.bank_select_register <= `BSR_RESET;
      s_r.ptr <= {3{`PTR_RESET}};
      s_r.daddr <= `DADDR_RESET;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // data memory has no reset; contents are undefined until written
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ptr_high_write: assert property (
    (exec_q3 && !s_r.word2 && dif.kind == K_PTR) |=>
      (s_r.ptr[$past(dif.sel)][11:8] == $past(dif.k_hi)) && (s_r.st == ST_WAIT))
    else $error("pointer high nibble not loaded in word one");

  a_ptr_low_write: assert property (
    (exec_q3 && s_r.word2 && s_r.kind == K_PTR) |=>
      (s_r.ptr[$past(s_r.first[5:4])][7:0] == $past(s_r.insn[7:0])) && (s_r.st == ST_IDLE))
    else $error("pointer low byte not loaded in word two");

  a_move_to_acc: assert property (
    (exec_q3 && !s_r.word2 && dif.kind == K_FMOVE && !dif.dest_bit) |=>
      (s_r.acc == $past(s_r.tmp)) && (s_r.zero == ($past(s_r.tmp) == 8'h00))
      && (s_r.neg == $past(s_r.tmp[7])))
    else $error("file move to accumulator wrong");

  a_move_back_file: assert property (
    (exec_q3 && !s_r.word2 && dif.kind == K_FMOVE && dif.dest_bit && faddr != `ACC_ADDR)
      |-> mem_we && (mem_wa == faddr) ##1 $stable(s_r.acc))
    else $error("file move did not write back to file");

  a_access_bank: assert property (
    (!dif.access_bit && !(s_r.ext_en && dif.f8 <= `INDEXED_LIMIT)) |->
      (faddr[7:0] == dif.f8) && (faddr[11:8] == (dif.f8[7] ? `ACCESS_HI_PAGE : 4'h0)))
    else $error("access bank address wrong");

  a_banked_addr: assert property (
    dif.access_bit |-> (faddr == {s_r.bank_select_register, dif.f8}))
    else $error("banked address wrong");

  a_indexed_addr: assert property (
    (!dif.access_bit && s_r.ext_en && dif.f8 <= `INDEXED_LIMIT) |->
      (faddr == s_r.ptr[`INDEX_PTR] + {4'h0, dif.f8}))
    else $error("indexed offset address wrong");

  a_full_decode: assert property (
    (dif.word[15:12] == 4'hC) |-> (dif.kind == K_FULL))
    else $error("full space move not decoded");

  a_full_dest: assert property (
    (exec_q3 && s_r.word2 && s_r.kind == K_FULL && s_r.insn[11:0] != `ACC_ADDR) |->
      mem_we && (mem_wa == s_r.insn[11:0]) && (mem_wd == s_r.tmp))
    else $error("full space move destination wrong");

  a_flags_kept: assert property (
    (s_r.st == ST_EXEC && wkind == K_FULL) |=> $stable(s_r.neg) && $stable(s_r.zero))
    else $error("full space move changed flags");

  a_no_dummy_read: assert property (
    (s_r.st == ST_EXEC && s_r.word2 && s_r.q == `Q_DECODE) |=> $stable(s_r.tmp) [*3])
    else $error("second word disturbed the source byte");

  a_bank_load: assert property (
    (exec_q3 && !s_r.word2 && dif.kind == K_BANK) |=> (s_r.bank_select_register == $past(s_r.insn[3:0])))
    else $error("bank select not loaded");

endmodule // data_move_instruction_exec
`default_nettype wire

// >>> pkg/dmx_params.svh
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets (haddr[7:0])
// ----------------------------------------------------------------------------
`define REG_INSN 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_ACC 8'h0C
`define REG_BANK 8'h10
`define REG_PTR0 8'h14
`define REG_PTR2 8'h1C
`define REG_DADDR 8'h20
`define REG_DDATA 8'h24
`define PTR0_INDEX 3'h5

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_EXT_BIT 0
`define CTRL_SKIP_BIT 1
`define STAT_OVR_BIT 2
`define STAT_SEQ_BIT 3
`define HSIZE_WORD 3'h2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACC_RESET 8'h00
`define BSR_RESET 4'h0
`define PTR_RESET 12'h000
`define DADDR_RESET 12'h000

// ----------------------------------------------------------------------------
// instruction timing: quarter phases of one instruction cycle
// ----------------------------------------------------------------------------
`define Q_DECODE 2'h0
`define Q_READ 2'h1
`define Q_WRITE 2'h3

// ----------------------------------------------------------------------------
// encodings and data space layout
// ----------------------------------------------------------------------------
`define PTRLOAD_MASK 16'hFFC0
`define PTRLOAD_CODE 16'hEE00
`define FILEMOVE_MASK 16'hFC00
`define FILEMOVE_CODE 16'h5000
`define FULLMOVE_MASK 16'hF000
`define FULLMOVE_CODE 16'hC000
`define SECOND_CODE 16'hF000
`define BANKLOAD_MASK 16'hFF00
`define BANKLOAD_CODE 16'h0100
`define ACC_ADDR 12'hFF0
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_PAGE 4'hF
`define INDEXED_LIMIT 8'h5F
`define INDEX_PTR 2'h2
`define PTR_COUNT 2'h3

`endif

// >>> pkg/dmx_pkg.sv
`default_nettype none
package dmx_pkg;

  typedef enum logic [2:0] {
    K_NOP = 3'b000,
    K_PTR = 3'b001,
    K_FMOVE = 3'b010,
    K_FULL = 3'b011,
    K_BANK = 3'b100,
    K_SECOND = 3'b101
  } kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } exec_state_t;

  typedef struct packed {
    exec_state_t st;
    logic [1:0] q;
    logic word2;
    logic nop;
    kind_t kind;
    logic [15:0] insn;
    logic [15:0] first;
    logic [7:0] tmp;
    logic [7:0] acc;
    logic [3:0] bank_select_register;
    logic [2:0][11:0] ptr;
    logic neg;
    logic zero;
    logic ext_en;
    logic skip_next;
    logic overrun;
    logic seq_err;
    logic [11:0] daddr;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } core_state_t;

endpackage
`default_nettype wire

// >>> pkg/decode_if.sv
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  import dmx_pkg::*;
  logic [15:0] word;
  kind_t kind;
  logic [7:0] f8;
  logic dest_bit;
  logic access_bit;
  logic [1:0] sel;
  logic [3:0] k_hi;

  modport decoder (input word, output kind, f8, dest_bit, access_bit, sel, k_hi);
  modport core (output word, input kind, f8, dest_bit, access_bit, sel, k_hi);
endinterface
`default_nettype wire

// >>> src/insn_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmx_params.svh"

module insn_decode
  import dmx_pkg::*;
(
  decode_if.decoder dif
);

  // ---------------------------------------------------------------------------
  // opcode classification
  // ---------------------------------------------------------------------------
  // a second word also matches nothing else, so its prefix is decoded here as a kind of its own
  always_comb begin
    if ((dif.word & `PTRLOAD_MASK) == `PTRLOAD_CODE) begin
      dif.kind = K_PTR;
    end else if ((dif.word & `FILEMOVE_MASK) == `FILEMOVE_CODE) begin
      dif.kind = K_FMOVE;
    end else if ((dif.word & `FULLMOVE_MASK) == `FULLMOVE_CODE) begin
      dif.kind = K_FULL;
    end else if ((dif.word & `FULLMOVE_MASK) == `SECOND_CODE) begin
      dif.kind = K_SECOND;
    end else if ((dif.word & `BANKLOAD_MASK) == `BANKLOAD_CODE) begin
      dif.kind = K_BANK;
    end else begin
      dif.kind = K_NOP;
    end
  end

  // operand fields
  assign dif.f8 = dif.word[7:0];
  assign dif.dest_bit = dif.word[9];
  assign dif.access_bit = dif.word[8];
  assign dif.sel = dif.word[5:4];
  assign dif.k_hi = dif.word[3:0];

endmodule // insn_decode
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmx_params.svh"

module testbench;
  import dmx_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors, check_count, cycles;
  logic [15:0] fm_insn [5] = '{16'h5123, 16'h5010, 16'h5085, 16'h5005, 16'h5060};
  logic [31:0] fm_ctrl [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
  logic [7:0] fm_acc [5] = '{8'h80, 8'h00, 8'h42, 8'h77, 8'h19};
  logic [1:0] fm_nz [5] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00};
  logic [15:0] pl_w1 [3] = '{16'hEE0F, 16'hEE11, 16'hEE23};
  logic [15:0] pl_w2 [3] = '{16'hF0FF, 16'hF022, 16'hF0AB};
  logic [31:0] pl_exp [3] = '{32'hFFF, 32'h122, 32'h3AB};

  // ----------------------------------------------------------------
  // clock, single slave so hready follows hreadyout
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  assign hready = hreadyout;

  data_move_instruction_exec DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  // ----------------------------------------------------------------
  // verdict and hang guard
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // budget well above the ~170 transfers and polls the tests need
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus cycles: address phase held until hready, then data phase
  // ----------------------------------------------------------------
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= `HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // one instruction word, then poll busy until it drops
  task automatic exec(input logic [15:0] w);
    int n;
    wr(`REG_INSN, {16'h0000, w});
    n = 0;
    do begin
      ahb_xfer(1'b0, `REG_STATUS, 32'h0);
      n = n + 1;
    end while (rd[0] !== 1'b0 && n < 30);
    check({31'h0, rd[0]}, 32'h0);
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(`REG_DADDR, {20'h00000, a});
    wr(`REG_DDATA, {24'h000000, d});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
    wr(`REG_DADDR, {20'h00000, a});
    rd_chk(`REG_DDATA, {24'h000000, d});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`REG_ACC, 32'h0);
    rd_chk(`REG_BANK, 32'h0);
    rd_chk(8'h40, 32'h0);
    // literal upper nibble dropped
    exec(16'h01FA);
    rd_chk(`REG_BANK, 32'hA);
    exec(16'h0105);
    rd_chk(`REG_BANK, 32'h5);
    // high part lands with the first word, low byte with the second
    for (int i = 0; i < 3; i++) begin
      exec(pl_w1[i]);
      rd_chk(`REG_PTR0 + 8'(4 * i), pl_exp[i] & 32'hF00);
      exec(pl_w2[i]);
      rd_chk(`REG_PTR0 + 8'(4 * i), pl_exp[i]);
    end
    // pointer select 3 names no pointer: both words act as no operation
    exec(16'hEE35);
    exec(16'hF0CC);
    rd_chk(`REG_PTR2, 32'h3AB);
    mem_wr(12'h523, 8'h80);
    mem_wr(12'h010, 8'h00);
    mem_wr(12'hF85, 8'h42);
    mem_wr(12'h3B0, 8'h77);
    mem_wr(12'h060, 8'h19);
    mem_wr(12'h123, 8'h5A);
    mem_wr(12'h456, 8'h11);
    mem_wr(12'hFFF, 8'hC3);
    // banked, access low, access high, indexed, direct above the index limit
    for (int i = 0; i < 5; i++) begin
      wr(`REG_CTRL, fm_ctrl[i]);
      exec(fm_insn[i]);
      rd_chk(`REG_ACC, {24'h000000, fm_acc[i]});
      ahb_xfer(1'b0, `REG_STATUS, 32'h0);
      check({30'h0, rd[5:4]}, {30'h0, fm_nz[i]});
      check({30'h0, rd[1:0]}, 32'h0);
    end
    wr(`REG_CTRL, 32'h0);
    // write back leaves the accumulator alone
    exec(16'h5323);
    rd_chk(`REG_ACC, 32'h19);
    mem_chk(12'h523, 8'h80);
    // full space moves with a nonzero bank select
    // destinations kept off program counter low and stack top bytes
    exec(16'hC123);
    ahb_xfer(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    exec(16'hF456);
    mem_chk(12'h456, 8'h5A);
    ahb_xfer(1'b0, `REG_STATUS, 32'h0);
    check({30'h0, rd[5:4]}, 32'h1);
    exec(16'hCFFF);
    exec(16'hFFF0);
    rd_chk(`REG_ACC, 32'hC3);
    exec(16'hCFF0);
    exec(16'hF789);
    mem_chk(12'h789, 8'hC3);
    // skipped two-word move writes nothing
    // source byte differs from the target's, so a leaked write would show
    wr(`REG_CTRL, 32'h2);
    exec(16'hC010);
    exec(16'hF456);
    mem_chk(12'h456, 8'h5A);
    rd_chk(`REG_CTRL, 32'h0);
    // broken pair: second word not of the continuation form
    exec(16'hC123);
    exec(16'h0107);
    rd_chk(`REG_BANK, 32'h5);
    ahb_xfer(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    wr(`REG_STATUS, 32'h8);
    ahb_xfer(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h0);
    // second word written while busy is dropped
    wr(`REG_INSN, 32'h0103);
    exec(16'h0109);
    rd_chk(`REG_BANK, 32'h3);
    ahb_xfer(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, rd[2]}, 32'h1);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
